// file: design/dcf_fifo.sv
// fifo top: bit-addressed 4608-bit store, pointers, flags and read path
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo
  import dcf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] write_width_sel_i,
  input wire logic [2:0] read_width_sel_i,
  input wire logic write_block_n_i,
  input wire logic read_block_n_i,
  input wire logic write_en_i,
  input wire logic read_en_i,
  input wire logic write_en_high_i,
  input wire logic read_en_low_i,
  input wire logic pipeline_read_sel_i,
  input wire logic empty_stop_i,
  input wire logic full_stop_i,
  input wire logic [17:0] write_data_i,
  input wire logic [11:0] almost_full_level_i,
  input wire logic [11:0] almost_empty_level_i,
  input wire logic read_ready_i,
  output logic [17:0] read_data_o,
  output logic read_valid_o,
  output logic full_o,
  output logic almost_full_flag_o,
  output logic empty_o,
  output logic almost_empty_flag_o,
  output logic [11:0] write_pointer_o,
  output logic [11:0] read_pointer_o
);

  // storage: one bit per cell so every aspect ratio shares the same array
  logic mem_ff [0:DCF_MEM_BITS-1];

  // write side state
  logic [12:0] wcnt_ff;
  logic [12:0] wgray_ff;
  logic full_ff;
  logic almost_full_flag_ff;
  logic [11:0] write_pointer_ff;

  // read side state
  logic [12:0] rcnt_ff;
  logic [12:0] rgray_ff;
  logic empty_ff;
  logic almost_empty_flag_ff;
  logic [11:0] read_pointer_ff;
  logic pipe_vld_ff;
  dcf_rword_t pipe_ff;

  // geometry of each port, decoded from its width select
  dcf_geom_t w_geo;
  dcf_geom_t r_geo;
  assign w_geo = dcf_geom(write_width_sel_i);
  assign r_geo = dcf_geom(read_width_sel_i);

  // counter masks: lap bit plus address, and address alone
  logic [12:0] w_cmask;
  logic [12:0] r_cmask;
  logic [12:0] w_amask;
  logic [12:0] r_amask;
  assign w_cmask = dcf_cnt_mask(w_geo.alog);
  assign r_cmask = dcf_cnt_mask(r_geo.alog);
  assign w_amask = w_cmask >> 1;
  assign r_amask = r_cmask >> 1;

  // capacities in bits, per side
  logic [13:0] w_cap;
  logic [13:0] r_cap;
  assign w_cap = dcf_cap(w_geo);
  assign r_cap = dcf_cap(r_geo);

  // opposite-domain counters, gray coded through two flops
  logic [12:0] rcnt_in_w;
  logic [12:0] wcnt_in_r;

  dcf_gray_sync #(
    .W(DCF_CNT_W)
  ) u_rptr_to_w (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .gray_i(rgray_ff),
    .bin_o(rcnt_in_w)
  );

  dcf_gray_sync #(
    .W(DCF_CNT_W)
  ) u_wptr_to_r (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .gray_i(wgray_ff),
    .bin_o(wcnt_in_r)
  );

  // write request: block enable low and enable at its chosen level
  logic w_req;
  logic w_adv;
  logic w_store;
  assign w_req = ~write_block_n_i & (write_en_i == write_en_high_i) & w_geo.ok;
  // full-stop high freezes the counter once full; low lets it lap on
  assign w_adv = w_req & (~full_ff | ~full_stop_i);
  // the store itself is always refused while full, so nothing is overrun
  assign w_store = w_req & ~full_ff;

  // next write counter, wrapping at twice the depth of the chosen geometry
  logic [12:0] nxt_wcnt;
  logic [12:0] wcnt_inc;
  assign wcnt_inc = (wcnt_ff + DCF_CNT_ONE) & w_cmask;
  assign nxt_wcnt = w_adv ? wcnt_inc : wcnt_ff;

  // bit positions seen by the write side; read position is the delayed copy
  logic [13:0] w_wpos;
  logic [13:0] w_rpos;
  logic [13:0] w_occ;
  assign w_wpos = 14'(nxt_wcnt) * 14'(w_geo.width);
  assign w_rpos = 14'(rcnt_in_w & r_cmask) * 14'(r_geo.width);
  assign w_occ = dcf_occ(w_wpos, w_rpos, w_cap);

  // full when another word would not fit; almost full against a bit level
  logic nxt_full;
  logic nxt_almost_full_flag;
  assign nxt_full = (w_occ + 14'(w_geo.width)) > w_cap;
  assign nxt_almost_full_flag = w_occ >= 14'(almost_full_level_i);

  // base bit of the write word inside the store
  logic [13:0] w_base;
  assign w_base = 14'(wcnt_ff & w_amask) * 14'(w_geo.width);

  // write counter, its gray copy for the read side, and the write flags
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wcnt_ff <= DCF_CNT_RST;
      wgray_ff <= DCF_CNT_RST;
      write_pointer_ff <= DCF_CNT_RST[11:0];
      full_ff <= 1'b0;
      almost_full_flag_ff <= 1'b0;
    end else begin
      wcnt_ff <= nxt_wcnt;
      wgray_ff <= nxt_wcnt ^ (nxt_wcnt >> 1);
      write_pointer_ff <= nxt_wcnt[11:0] & w_amask[11:0];
      full_ff <= nxt_full;
      almost_full_flag_ff <= nxt_almost_full_flag;
    end
  end

  // store the low bits of the word; upper write bits are never looked at
  always_ff @(posedge clk_i) begin
    if (w_store) begin
      for (int i = 0; i < DCF_DATA_W; i++) begin
        if (i < int'(w_geo.width)) begin
          mem_ff[int'(w_base) + i] <= write_data_i[i];
        end
      end
    end
  end

  // read path room: the pipe stage and the buffer must be able to take the word
  logic buf_in_ready;
  logic r_room;
  assign r_room = pipeline_read_sel_i ? (~pipe_vld_ff | buf_in_ready)
                                      : (~pipe_vld_ff & buf_in_ready);

  // read request: block enable low, enable at its chosen level, room downstream
  logic r_req;
  logic r_adv;
  assign r_req = ~read_block_n_i & ((read_en_i ^ read_en_low_i) == 1'b1)
                 & r_geo.ok & r_room;
  // empty-stop low lets the counter run on so stored words replay
  assign r_adv = r_req & (~empty_ff | ~empty_stop_i);

  // next read counter, same wrap as the write side
  logic [12:0] nxt_rcnt;
  logic [12:0] rcnt_inc;
  assign rcnt_inc = (rcnt_ff + DCF_CNT_ONE) & r_cmask;
  assign nxt_rcnt = r_adv ? rcnt_inc : rcnt_ff;

  // bit positions seen by the read side; write position is the delayed copy
  logic [13:0] r_wpos;
  logic [13:0] r_rpos;
  logic [13:0] r_occ;
  assign r_wpos = 14'(wcnt_in_r & w_cmask) * 14'(w_geo.width);
  assign r_rpos = 14'(nxt_rcnt) * 14'(r_geo.width);
  assign r_occ = dcf_occ(r_wpos, r_rpos, r_cap);

  // empty when less than one read word is held
  logic nxt_empty;
  logic nxt_almost_empty_flag;
  assign nxt_empty = r_occ < 14'(r_geo.width);
  assign nxt_almost_empty_flag = r_occ <= 14'(almost_empty_level_i);

  // read word fetched from the current read address; unused bits read zero
  logic [13:0] r_base;
  dcf_rword_t r_word;
  assign r_base = 14'(rcnt_ff & r_amask) * 14'(r_geo.width);
  always_comb begin
    r_word = '{data: DCF_RDATA_RST};
    for (int i = 0; i < DCF_DATA_W; i++) begin
      if (i < int'(r_geo.width)) begin
        r_word.data[i] = mem_ff[int'(r_base) + i];
      end
    end
  end

  // feed the buffer: a held pipe word first, else the fresh word in direct mode
  logic buf_in_valid;
  dcf_rword_t buf_in_data;
  logic pipe_push;
  logic pipe_load;
  // a held pipe word waits while the read block is off, so the outputs cannot move
  assign buf_in_valid = (pipe_vld_ff & ~read_block_n_i) | (~pipeline_read_sel_i & r_adv);
  assign buf_in_data = pipe_vld_ff ? pipe_ff : r_word;
  assign pipe_push = pipe_vld_ff & buf_in_ready & ~read_block_n_i;
  assign pipe_load = pipeline_read_sel_i & r_adv;

  // read counter, its gray copy, flags and the extra pipeline stage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rcnt_ff <= DCF_CNT_RST;
      rgray_ff <= DCF_CNT_RST;
      read_pointer_ff <= DCF_CNT_RST[11:0];
      empty_ff <= 1'b1;
      almost_empty_flag_ff <= 1'b1;
      pipe_vld_ff <= 1'b0;
      pipe_ff <= '{data: DCF_RDATA_RST};
    end else begin
      rcnt_ff <= nxt_rcnt;
      rgray_ff <= nxt_rcnt ^ (nxt_rcnt >> 1);
      read_pointer_ff <= nxt_rcnt[11:0] & r_amask[11:0];
      empty_ff <= nxt_empty;
      almost_empty_flag_ff <= nxt_almost_empty_flag;
      pipe_vld_ff <= pipe_load | (pipe_vld_ff & ~pipe_push);
      if (pipe_load) begin
        pipe_ff <= r_word;
      end
    end
  end

  // the buffer head only advances while the read block is enabled,
  // so a high block enable keeps the last word on the outputs
  logic buf_out_ready;
  dcf_rword_t buf_out_data;
  assign buf_out_ready = read_ready_i & ~read_block_n_i;

  dcf_out_buf u_out_buf (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(buf_in_data),
    .out_valid_o(read_valid_o),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  // outputs straight from flops
  assign read_data_o = buf_out_data.data;
  assign full_o = full_ff;
  assign almost_full_flag_o = almost_full_flag_ff;
  assign empty_o = empty_ff;
  assign almost_empty_flag_o = almost_empty_flag_ff;
  assign write_pointer_o = write_pointer_ff;
  assign read_pointer_o = read_pointer_ff;

endmodule
`default_nettype wire

// file: common/dcf_pkg.sv
// constants, carriers and helpers shared by the dual-clock fifo block
package dcf_pkg;

  localparam int unsigned DCF_DATA_W = 18;
  localparam int unsigned DCF_ADDR_W = 12;
  localparam int unsigned DCF_CNT_W = 13;
  localparam int unsigned DCF_POS_W = 14;
  localparam int unsigned DCF_LVL_W = 12;
  localparam int unsigned DCF_MEM_BITS = 4608;
  localparam logic [17:0] DCF_RDATA_RST = 18'h00000;
  localparam logic [12:0] DCF_CNT_RST = 13'h0000;
  localparam logic [12:0] DCF_CNT_ONE = 13'h0001;
  localparam logic [12:0] DCF_CNT_ALL = 13'h1fff;
  localparam logic [3:0] DCF_ALOG_MAX = 4'hc;

  // width select codes; the three upper codes are reserved
  typedef enum logic [2:0] {
    DCF_W1 = 3'h0,
    DCF_W2 = 3'h1,
    DCF_W4 = 3'h2,
    DCF_W9 = 3'h3,
    DCF_W18 = 3'h4
  } dcf_width_t;

  // port geometry: word width, log2 of depth, code legal
  typedef struct packed {
    logic [4:0] width;
    logic [3:0] alog;
    logic ok;
  } dcf_geom_t;

  // one read word on its way to the user
  typedef struct packed {
    logic [17:0] data;
  } dcf_rword_t;

  function automatic dcf_geom_t dcf_geom(input logic [2:0] sel);
    dcf_geom_t g;
    g = '{width: 5'h01, alog: 4'hc, ok: 1'b0};
    unique case (dcf_width_t'(sel))
      DCF_W1: g = '{width: 5'h01, alog: 4'hc, ok: 1'b1};
      DCF_W2: g = '{width: 5'h02, alog: 4'hb, ok: 1'b1};
      DCF_W4: g = '{width: 5'h04, alog: 4'ha, ok: 1'b1};
      DCF_W9: g = '{width: 5'h09, alog: 4'h9, ok: 1'b1};
      DCF_W18: g = '{width: 5'h12, alog: 4'h8, ok: 1'b1};
      default: g = '{width: 5'h01, alog: 4'hc, ok: 1'b0};
    endcase
    return g;
  endfunction

  // counter mask covering address plus lap bit (twice the depth)
  function automatic logic [12:0] dcf_cnt_mask(input logic [3:0] alog);
    return DCF_CNT_ALL >> (DCF_ALOG_MAX - alog);
  endfunction

  // capacity in bits for a geometry
  function automatic logic [13:0] dcf_cap(input dcf_geom_t g);
    return 14'(g.width) << g.alog;
  endfunction

  // bit occupancy between two bit positions, modulo twice the capacity
  function automatic logic [13:0] dcf_occ(input logic [13:0] wpos, input logic [13:0] rpos,
                                          input logic [13:0] cap);
    logic [13:0] d;
    d = wpos - rpos;
    if (wpos < rpos) begin
      d = d + (cap << 1);
    end
    return d;
  endfunction

endpackage

// file: design/dcf_gray_sync.sv
// two-stage synchroniser for a gray-coded counter, with binary result
`timescale 1ns/1ps
`default_nettype none
module dcf_gray_sync
  import dcf_pkg::*;
#(
  parameter int unsigned W = 13
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] gray_i,
  output logic [W-1:0] bin_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage is read by the second stage only
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= gray_i;
      sync_ff <= meta_ff;
    end
  end

  // gray to binary: each bit is the xor of its own gray bit and all gray bits above it
  always_comb begin
    bin_o[W-1] = sync_ff[W-1];
    for (int i = W - 2; i >= 0; i--) begin
      bin_o[i] = bin_o[i+1] ^ sync_ff[i];
    end
  end

endmodule
`default_nettype wire

// file: design/dcf_out_buf.sv
// two-entry read buffer: output register plus one skid slot
`timescale 1ns/1ps
`default_nettype none
module dcf_out_buf
  import dcf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire dcf_rword_t in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output dcf_rword_t out_data_o
);

  logic sk_vld_ff;
  dcf_rword_t sk_ff;

  // ready comes from a flop so the source sees no combinational path
  assign in_ready_o = ~sk_vld_ff;

  // head moves on when consumed or empty; the slot catches a word under stall
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '{data: DCF_RDATA_RST};
      sk_vld_ff <= 1'b0;
      sk_ff <= '{data: DCF_RDATA_RST};
    end else if (out_ready_i || !out_valid_o) begin
      if (sk_vld_ff) begin
        out_data_o <= sk_ff;
        out_valid_o <= 1'b1;
        sk_vld_ff <= 1'b0;
      end else begin
        out_valid_o <= in_valid_i;
        if (in_valid_i) begin
          out_data_o <= in_data_i;
        end
      end
    end else if (in_valid_i && !sk_vld_ff) begin
      sk_ff <= in_data_i;
      sk_vld_ff <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: sim/dcf_user_model.sv
// user-side consumer of the fifo read stream, with stall patterns
`timescale 1ns/1ps
`default_nettype none
module dcf_user_model
  import dcf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hold_i,
  input wire logic slow_i,
  input wire logic [17:0] mask_i,
  input wire logic valid_i,
  input wire logic [17:0] data_i,
  output logic ready_o,
  output logic got_o,
  output logic [17:0] word_o
);
  // ready moves only after an edge; slow mode stalls every other cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ready_o <= 1'b0;
      got_o <= 1'b0;
      word_o <= 18'h00000;
    end else begin
      ready_o <= !hold_i && !(slow_i && ready_o);
      got_o <= valid_i && ready_o;
      word_o <= data_i & mask_i;
    end
  end
endmodule
`default_nettype wire

// file: sim/dcf_fifo_props.sv
// concurrent checks on the fifo top ports
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_props
  import dcf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] write_width_sel_i,
  input wire logic [2:0] read_width_sel_i,
  input wire logic write_block_n_i,
  input wire logic read_block_n_i,
  input wire logic write_en_i,
  input wire logic read_en_i,
  input wire logic write_en_high_i,
  input wire logic read_en_low_i,
  input wire logic pipeline_read_sel_i,
  input wire logic empty_stop_i,
  input wire logic full_stop_i,
  input wire logic [17:0] read_data_o,
  input wire logic read_valid_o,
  input wire logic full_o,
  input wire logic empty_o,
  input wire logic [11:0] write_pointer_o,
  input wire logic [11:0] read_pointer_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // accepted write in the 256 x18 geometry
  sequence wr_take;
    !write_block_n_i && write_en_i == write_en_high_i && !full_o && write_width_sel_i == 3'h4;
  endsequence
  // direct read into an idle output stage
  sequence rd_take;
    !read_block_n_i && read_en_i != read_en_low_i && !empty_o && read_width_sel_i < 3'h5
      && !pipeline_read_sel_i && !read_valid_o;
  endsequence
  // first write step after a quiet spell, seen while still empty
  sequence wr_first;
    $stable(write_pointer_o) [*3] ##1 ($changed(write_pointer_o) && empty_o);
  endsequence
  // first read step after a quiet spell, seen while still full
  sequence rd_first;
    $stable(read_pointer_o) [*3] ##1 ($changed(read_pointer_o) && full_o);
  endsequence
  // reset must win even though the default disable would hide it
  reset_state_a: assert property (disable iff (1'b0) !rstn_i |=> empty_o && !full_o
    && read_data_o == 18'h00000 && write_pointer_o == 12'h000 && read_pointer_o == 12'h000)
    else $error("reset state wrong");
  wr_step_a: assert property (wr_take |=>
    write_pointer_o == (($past(write_pointer_o) + 12'h001) & 12'h0ff))
    else $error("write pointer step wrong");
  rd_latency_a: assert property (rd_take |=> read_valid_o)
    else $error("direct read late");
  full_hold_a: assert property (full_o && full_stop_i |=> $stable(write_pointer_o))
    else $error("write counter moved while full");
  empty_hold_a: assert property (empty_o && empty_stop_i |=> $stable(read_pointer_o))
    else $error("read counter moved while empty");
  block_hold_a: assert property (read_block_n_i |=> $stable(read_data_o))
    else $error("read data moved while blocked");
  empty_release_a: assert property (wr_first |-> empty_o [*3])
    else $error("empty released early");
  full_release_a: assert property (rd_first |-> full_o [*3])
    else $error("full released early");
  reserved_code_a: assert property (write_width_sel_i > 3'h4 |=> $stable(write_pointer_o))
    else $error("reserved width wrote");
endmodule
bind dcf_fifo dcf_fifo_props i_dcf_fifo_props (.clk_i(clk_i), .rstn_i(rstn_i),
  .write_width_sel_i(write_width_sel_i), .read_width_sel_i(read_width_sel_i),
  .write_block_n_i(write_block_n_i), .read_block_n_i(read_block_n_i),
  .write_en_i(write_en_i), .read_en_i(read_en_i), .write_en_high_i(write_en_high_i),
  .read_en_low_i(read_en_low_i), .pipeline_read_sel_i(pipeline_read_sel_i),
  .empty_stop_i(empty_stop_i), .full_stop_i(full_stop_i), .read_data_o(read_data_o),
  .read_valid_o(read_valid_o), .full_o(full_o), .empty_o(empty_o),
  .write_pointer_o(write_pointer_o), .read_pointer_o(read_pointer_o));
`default_nettype wire

// file: sim/dcf_fifo_test.sv
// self-checking bench for the fifo top
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_test;
  logic clk_i = 1'b0, rstn_i = 1'b0;
  logic [2:0] wws = 3'h4, rws = 3'h4;
  logic wbn = 1'b0, rbn = 1'b0, wen = 1'b1, ren = 1'b0, wpol = 1'b0, rpol = 1'b0;
  logic pipe = 1'b0, empty_stop = 1'b1, full_stop = 1'b1, hold = 1'b0, slow = 1'b0;
  logic [17:0] wd = 18'h00000, mask = 18'h3ffff;
  logic [11:0] afl = 12'hfff, ael = 12'h000;
  logic [17:0] masks [5] = '{18'h00001, 18'h00003, 18'h0000f, 18'h001ff, 18'h3ffff};
  wire logic rdy, rvalid, full, almost_full_flag, empty, almost_empty_flag, got;
  wire logic [17:0] rdata, word;
  wire logic [11:0] wptr, rptr;
  int failures = 0, checks_done = 0;
  dcf_fifo i_dcf_fifo (.clk_i(clk_i), .rstn_i(rstn_i), .write_width_sel_i(wws),
    .read_width_sel_i(rws), .write_block_n_i(wbn), .read_block_n_i(rbn), .write_en_i(wen),
    .read_en_i(ren), .write_en_high_i(wpol), .read_en_low_i(rpol), .pipeline_read_sel_i(pipe),
    .empty_stop_i(empty_stop), .full_stop_i(full_stop), .write_data_i(wd), .almost_full_level_i(afl),
    .almost_empty_level_i(ael), .read_ready_i(rdy), .read_data_o(rdata), .read_valid_o(rvalid),
    .full_o(full), .almost_full_flag_o(almost_full_flag), .empty_o(empty), .almost_empty_flag_o(almost_empty_flag),
    .write_pointer_o(wptr), .read_pointer_o(rptr));
  dcf_user_model i_dcf_user_model (.clk_i(clk_i), .rstn_i(rstn_i), .hold_i(hold),
    .slow_i(slow), .mask_i(mask), .valid_i(rvalid), .data_i(rdata), .ready_o(rdy), .got_o(got),
    .word_o(word));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic do_reset();
    rstn_i <= 1'b0;
    idle(3);
    rstn_i <= 1'b1;
    @(posedge clk_i);
  endtask
  // back-to-back writes; unused upper bits are grounded by the writer
  task automatic wr_n(input int n, input logic [17:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      wen <= wpol;
      wd <= (base + 18'(i)) & mask;
    end
    @(posedge clk_i);
    wen <= ~wpol;
  endtask
  // read until n words arrived; empty-stop refuses any extra read
  task automatic rd_all(input int n, input logic [17:0] base);
    int k;
    k = 0;
    @(posedge clk_i);
    ren <= ~rpol;
    for (int t = 0; t < 2000 && k < n; t++) begin
      @(posedge clk_i);
      if (got === 1'b1) begin
        chk("read word", word, (base + 18'(k)) & mask);
        k++;
      end
    end
    ren <= rpol;
    chk("word count", 18'(k), 18'(n));
  endtask
  // every legal width code, both enable polarities set from the code's low bit
  task automatic t_codes();
    for (int c = 0; c < 5; c++) begin
      do_reset();
      wws <= 3'(c);
      rws <= 3'(c);
      mask <= masks[c];
      wpol <= c[0];
      rpol <= c[0];
      wen <= ~c[0];
      ren <= c[0];
      wr_n(3, 18'h15a5a);
      idle(6);
      rd_all(3, 18'h15a5a);
    end
  endtask
  // threshold boundaries, then a stalled consumer fills the read buffer
  task automatic t_stall();
    logic [17:0] d;
    do_reset();
    wr_n(6, 18'h2c3c0);
    afl <= 12'h06c;
    ael <= 12'h06c;
    idle(8);
    chk("at threshold", {16'h0, almost_full_flag, almost_empty_flag}, 18'h00003);
    afl <= 12'h06d;
    ael <= 12'h06b;
    idle(3);
    chk("off threshold", {16'h0, almost_full_flag, almost_empty_flag}, 18'h00000);
    hold <= 1'b1;
    ren <= ~rpol;
    idle(12);
    chk("refused reads", 18'(rptr), 18'h00002);
    d = rdata;
    ren <= rpol;
    rbn <= 1'b1;
    hold <= 1'b0;
    idle(5);
    chk("blocked data", rdata, d);
    rbn <= 1'b0;
    slow <= 1'b1;
    rd_all(6, 18'h2c3c0);
    slow <= 1'b0;
    afl <= 12'hfff;
    ael <= 12'h000;
  endtask
  // pipelined read costs exactly one more cycle; then replay past empty
  task automatic t_pipe();
    int lat [2];
    logic [11:0] r;
    for (int p = 0; p < 2; p++) begin
      do_reset();
      pipe <= p[0];
      wr_n(1, 18'h1e1e1);
      idle(8);
      ren <= ~rpol;
      @(posedge clk_i);
      ren <= rpol;
      lat[p] = 0;
      while (got !== 1'b1 && lat[p] < 20) begin
        @(posedge clk_i);
        lat[p]++;
      end
      chk("pipe word", word, 18'h1e1e1);
    end
    chk("pipe delay", 18'(lat[1] - lat[0]), 18'h00001);
    pipe <= 1'b0;
    empty_stop <= 1'b0;
    r = rptr;
    ren <= ~rpol;
    @(posedge clk_i);
    ren <= rpol;
    idle(3);
    chk("replay pointer", 18'(rptr), 18'(r + 12'h001));
    empty_stop <= 1'b1;
  endtask
  task automatic t_fill();
    do_reset();
    afl <= 12'he10;
    wr_n(256, 18'h00000);
    idle(2);
    chk("full flags", {16'h0, full, almost_full_flag}, 18'h00003);
    chk("wrapped pointer", 18'(wptr), 18'h00000);
    wr_n(1, 18'h3ffff);
    // the refused write is sampled at this edge, so look one edge later
    idle(1);
    chk("stopped pointer", 18'(wptr), 18'h00000);
    ren <= ~rpol;
    @(posedge clk_i);
    ren <= rpol;
    idle(2);
    chk("full held", 18'(full), 18'h00001);
    idle(4);
    chk("full released", 18'(full), 18'h00000);
    // fill again, then full-stop low lets the counter lap on while full
    wr_n(1, 18'h00001);
    full_stop <= 1'b0;
    wr_n(1, 18'h00002);
    idle(1);
    chk("lapping pointer", 18'(wptr), 18'h00002);
    full_stop <= 1'b1;
  endtask
  // reset from a full store, then a reserved write width
  task automatic t_reset();
    do_reset();
    chk("reset flags", {14'h0, full, almost_full_flag, empty, almost_empty_flag}, 18'h00003);
    chk("reset data", rdata, 18'h00000);
    chk("reset pointers", {6'h0, wptr | rptr}, 18'h00000);
    wws <= 3'h5;
    wr_n(1, 18'h00001);
    idle(2);
    chk("reserved width", 18'(wptr), 18'h00000);
  endtask
  initial begin
    do_reset();
    t_codes();
    t_stall();
    t_pipe();
    t_fill();
    t_reset();
    finish_test();
  end
  // the whole run needs well under two thousand cycles
  initial begin
    idle(5000);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
